// ===== tpo_pkg.sv
package tpo_pkg;
   // Channel count and register widths
   localparam int TPO_NCH = 5;
   localparam int TPO_AW  = 9;
   localparam int TPO_DW  = 32;
   localparam int TPO_CW  = 16;

   // Byte offsets inside one channel window (window = channel * 0x20)
   localparam logic [4:0] OFS_MODE  = 5'h00;
   localparam logic [4:0] OFS_IOCTL = 5'h04;
   localparam logic [4:0] OFS_GRA   = 5'h08;
   localparam logic [4:0] OFS_GRB   = 5'h0c;
   localparam logic [4:0] OFS_GRC   = 5'h10;
   localparam logic [4:0] OFS_GRD   = 5'h14;

   // Byte offsets of the shared registers
   localparam logic [8:0] OFS_OUTCTL  = 9'h100;
   localparam logic [8:0] OFS_STATUS  = 9'h104;
   localparam logic [8:0] OFS_RUN     = 9'h108;
   localparam logic [8:0] OFS_DUTY_NX = 9'h10c;

   // Status register field positions
   localparam int ST_REFUSED = 0;
   localparam int ST_DOWN    = 1;
   localparam int ST_PIN_A   = 8;
   localparam int ST_PIN_C   = 16;

   // Operating modes, Gray coded along the usual path
   typedef enum logic [2:0] {
      MODE_NORMAL = 3'h0,
      MODE_PWM_MODE_ONE   = 3'h1,
      MODE_PWM_MODE_TWO   = 3'h3,
      MODE_PCM    = 3'h2,
      MODE_COMPLEMENTARY_PWM_MODE   = 3'h6,
      MODE_RESET_SYNC_PWM_MODE   = 3'h7
   } tpo_mode_t;

   // Per-channel io_control_reg layout
   typedef struct packed {
      logic buf_d;
      logic buf_c;
      logic init_c;
      logic init_a;
   } tpo_ioctl_t;

   // output_control_reg layout
   typedef struct packed {
      logic chop_en;
      logic negative_phase_level_select;
      logic positive_phase_level_select;
   } tpo_outctl_t;

   // Pin bundle driven toward the port logic
   typedef struct packed {
      logic [TPO_NCH-1:0] oe;
      logic [TPO_NCH-1:0] pin_c;
      logic [TPO_NCH-1:0] pin_a;
   } tpo_pins_t;

   // Reset values
   localparam tpo_ioctl_t  IOCTL_RST  = 4'h0;
   localparam tpo_outctl_t OUTCTL_RST = 3'h3;

   // Chopping carrier half period
   localparam int CLK_NS        = 25;
   localparam int CHOP_HALF_NS  = 200;
   localparam int CHOP_HALF_CYC = (CHOP_HALF_NS + CLK_NS - 1) / CLK_NS;
endpackage : tpo_pkg

// ===== tpo_output_ctrl.sv
module tpo_output_ctrl
   import tpo_pkg::*;
#(
   parameter int CW = TPO_CW
) (
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   input  wire logic [TPO_AW-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [TPO_DW-1:0] avs_writedata,
   output logic      [TPO_DW-1:0] avs_readdata,
   output logic                   avs_waitrequest,
   input  wire logic              sync_clear,
   input  wire logic              standby,
   input  wire logic              hw_output_cutoff,
   output tpo_pins_t              timer_out_pins
);

   // Counter width must fit a register word and allow a real period
   if (CW < 2 || CW > 16) begin : g_bad_cw
      $error("tpo_output_ctrl: CW must lie between 2 and 16");
   end

   // Mode legality for one channel
   function automatic logic mode_legal(input int ch, input tpo_mode_t m);
      case (m)
         MODE_PCM:  mode_legal = (ch == 1) || (ch == 2);
         MODE_COMPLEMENTARY_PWM_MODE,
         MODE_RESET_SYNC_PWM_MODE: mode_legal = (ch == 3) || (ch == 4);
         MODE_PWM_MODE_TWO: mode_legal = (ch <= 2);
         default:   mode_legal = 1'b1;
      endcase
   endfunction

   // Transition check between two modes
   function automatic logic trans_ok(input tpo_mode_t o, input tpo_mode_t n);
      logic o_cnt;
      logic n_cnt;
      logic o_cmp;
      logic n_cmp;
      o_cnt = (o == MODE_PWM_MODE_TWO) || (o == MODE_PCM);
      n_cnt = (n == MODE_PWM_MODE_TWO) || (n == MODE_PCM);
      o_cmp = (o == MODE_COMPLEMENTARY_PWM_MODE) || (o == MODE_RESET_SYNC_PWM_MODE);
      n_cmp = (n == MODE_COMPLEMENTARY_PWM_MODE) || (n == MODE_RESET_SYNC_PWM_MODE);
      trans_ok = !((o_cnt && n_cmp) || (o_cmp && n_cnt));
   endfunction

   // Register state
   tpo_mode_t          mode_ff  [TPO_NCH];   // Operating mode per channel
   tpo_ioctl_t         ioctl_ff [TPO_NCH];   // Initial levels and buffer enables
   logic [CW-1:0]      gra_ff   [TPO_NCH];   // Period / compare A
   logic [CW-1:0]      grb_ff   [TPO_NCH];   // Compare B
   logic [CW-1:0]      grc_ff   [TPO_NCH];   // Compare C
   logic [CW-1:0]      grd_ff   [TPO_NCH];   // Compare D
   logic [CW-1:0]      cnt_ff   [TPO_NCH];   // Channel counters
   logic [CW-1:0]      nxt_cnt  [TPO_NCH];
   logic [TPO_NCH-1:0] run_ff;               // Counter run enables
   tpo_outctl_t        outctl_ff;            // Complementary output control
   logic               refused_ff;           // Sticky: mode write refused
   logic               down_ff;              // Channel 3 counts down
   logic               nxt_down;
   logic [CW-1:0]      duty_cur_ff;          // Duty now compared
   logic [CW-1:0]      duty_nxt_ff;          // Duty for the next period
   logic [CW-1:0]      duty_fol_ff;          // Duty after that
   logic [7:0]         chop_cnt_ff;          // Carrier divider
   logic               chop_ff;              // Chopping carrier level
   logic               wait_ff;              // Bus wait state
   logic [TPO_DW-1:0]  rdata_ff;             // Registered read data
   tpo_pins_t          pins_ff;              // Pin outputs
   tpo_pins_t          nxt_pins;

   // Bus decode
   wire       take    = (avs_read || avs_write) && wait_ff;
   wire       wr_do   = avs_write && !wait_ff;
   wire       in_ch   = !avs_address[8] && (avs_address[7:5] < 3'(TPO_NCH));
   wire [2:0] ch_sel  = avs_address[7:5];
   wire [4:0] reg_sel = avs_address[4:0];
   wire       wr_ch   = wr_do && in_ch;
   wire       wr_mode = wr_ch && (reg_sel == OFS_MODE);
   wire       new_ok  = mode_legal(int'(ch_sel), tpo_mode_t'(avs_writedata[2:0]))
                        && trans_ok(mode_ff[ch_sel], tpo_mode_t'(avs_writedata[2:0]));
   wire       wr_fol  = wr_ch && (ch_sel == 3'h4) && (reg_sel == OFS_GRD);
   wire       wr_nx   = wr_do && (avs_address == OFS_DUTY_NX);
   wire       clr_ref = wr_do && (avs_address == OFS_STATUS) && avs_writedata[ST_REFUSED];

   // Complementary group state; mode, counter and period taken from channel 3, levels from output_control_reg
   wire cmp_on  = (mode_ff[3] == MODE_COMPLEMENTARY_PWM_MODE) || (mode_ff[3] == MODE_RESET_SYNC_PWM_MODE);
   wire tri_on  = mode_ff[3] == MODE_COMPLEMENTARY_PWM_MODE;
   wire crest   = tri_on && !down_ff && (cnt_ff[3] == gra_ff[3]);
   wire wrap3   = !tri_on && (cnt_ff[3] == gra_ff[3]);
   wire xfer    = cmp_on && run_ff[3] && (crest || wrap3);
   wire restart = cmp_on && sync_clear;
   wire act     = cnt_ff[3] < duty_cur_ff;
   wire chop_ok = !outctl_ff.chop_en || chop_ff;
   wire hi_p    = outctl_ff.positive_phase_level_select;
   wire hi_n    = outctl_ff.negative_phase_level_select;
   // Chopping is gated into the active phase only while the level is high-active
   wire act_p   = act && (hi_p ? chop_ok : 1'b1);
   wire act_n   = !act && (hi_n ? chop_ok : 1'b1);
   wire out_p   = hi_p ? act_p : !act_p;
   wire out_n   = hi_n ? act_n : !act_n;
   wire chop_en = chop_cnt_ff == 8'(CHOP_HALF_CYC - 1);

   // Read data selection
   function automatic logic [TPO_DW-1:0] rd_word(input logic [TPO_AW-1:0] a);
      logic [2:0] c;
      c = a[7:5];
      rd_word = '0;
      if (!a[8] && (c < 3'(TPO_NCH))) begin
         case (a[4:0])
            OFS_MODE:  rd_word = TPO_DW'(mode_ff[c]);
            OFS_IOCTL: rd_word = TPO_DW'(ioctl_ff[c]);
            OFS_GRA:   rd_word = TPO_DW'(gra_ff[c]);
            OFS_GRB:   rd_word = TPO_DW'(grb_ff[c]);
            OFS_GRC:   rd_word = TPO_DW'(grc_ff[c]);
            OFS_GRD:   rd_word = (c == 3'h4) ? TPO_DW'(duty_fol_ff) : TPO_DW'(grd_ff[c]);
            default:   rd_word = '0;
         endcase
      end else begin
         case (a)
            OFS_OUTCTL:  rd_word = TPO_DW'(outctl_ff);
            OFS_RUN:     rd_word = TPO_DW'(run_ff);
            OFS_DUTY_NX: rd_word = TPO_DW'(duty_nxt_ff);
            OFS_STATUS: begin
               rd_word[ST_REFUSED] = refused_ff;
               rd_word[ST_DOWN] = down_ff;
               rd_word[ST_PIN_A +: TPO_NCH] = pins_ff.pin_a;
               rd_word[ST_PIN_C +: TPO_NCH] = pins_ff.pin_c;
            end
            default:     rd_word = '0;
         endcase
      end
   endfunction

   // Counter next values; channel 3 turns at the crest and at zero in complementary mode
   always_comb begin
      nxt_down = down_ff;
      for (int i = 0; i < TPO_NCH; i++) begin
         nxt_cnt[i] = cnt_ff[i];
         if (run_ff[i]) begin
            if (i == 3 && tri_on) begin
               if (down_ff) begin
                  nxt_cnt[i] = cnt_ff[i] - 1'b1;
                  if (cnt_ff[i] == '0) begin
                     nxt_cnt[i] = cnt_ff[i] + 1'b1;
                     nxt_down = 1'b0;
                  end
               end else if (cnt_ff[i] == gra_ff[i]) begin
                  nxt_cnt[i] = cnt_ff[i] - 1'b1;
                  nxt_down = 1'b1;
               end else begin
                  nxt_cnt[i] = cnt_ff[i] + 1'b1;
               end
            end else if (cnt_ff[i] == gra_ff[i]) begin
               nxt_cnt[i] = '0;
            end else begin
               nxt_cnt[i] = cnt_ff[i] + 1'b1;
            end
         end
         // Sync clear restarts the complementary pair from zero
         if (restart && (i == 3 || i == 4)) begin
            nxt_cnt[i] = '0;
         end
      end
      if (restart || !tri_on) begin
         nxt_down = 1'b0;
      end
   end

   // Pin next values, per channel and mode
   always_comb begin
      logic c_ok;
      c_ok = 1'b0;
      nxt_pins = pins_ff;
      for (int i = 0; i < TPO_NCH; i++) begin
         // Pin C of PWM_MODE_ONE is lost when C or D buffers, save channel 0 with D alone
         c_ok = !(ioctl_ff[i].buf_c || ioctl_ff[i].buf_d)
                || (i == 0 && !ioctl_ff[i].buf_c);
         // Large-current pins of channels 3 and 4 follow the hardware cutoff
         nxt_pins.oe[i] = !(hw_output_cutoff && i >= 3);
         case (mode_ff[i])
            MODE_PWM_MODE_ONE: begin
               if (cnt_ff[i] == gra_ff[i]) begin
                  nxt_pins.pin_a[i] = ioctl_ff[i].init_a;
               end else if (cnt_ff[i] == grb_ff[i]) begin
                  nxt_pins.pin_a[i] = !ioctl_ff[i].init_a;
               end
               if (c_ok && cnt_ff[i] == grc_ff[i]) begin
                  nxt_pins.pin_c[i] = ioctl_ff[i].init_c;
               end else if (c_ok && cnt_ff[i] == grd_ff[i]) begin
                  nxt_pins.pin_c[i] = !ioctl_ff[i].init_c;
               end
            end
            MODE_COMPLEMENTARY_PWM_MODE, MODE_RESET_SYNC_PWM_MODE: begin
               nxt_pins.pin_c[i] = 1'b0;
            end
            default: begin
               nxt_pins.pin_a[i] = ioctl_ff[i].init_a;
               nxt_pins.pin_c[i] = ioctl_ff[i].init_c;
            end
         endcase
         // Channel 3 pin A carries the positive phase, channel 4 the negative
         if (cmp_on && i >= 3) begin
            if (restart) begin
               nxt_pins.pin_a[i] = (i == 3) ? !hi_p : !hi_n;
            end else begin
               nxt_pins.pin_a[i] = (i == 3) ? out_p : out_n;
            end
         end
         // Standby forces every pin low
         if (standby) begin
            nxt_pins.pin_a[i] = 1'b0;
            nxt_pins.pin_c[i] = 1'b0;
         end
      end
   end

   // Avalon slave handshake: one wait cycle, then the access completes
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wait_ff  <= 1'b1;
         rdata_ff <= '0;
      end else begin
         wait_ff  <= !take;
         // Only a read refreshes the data word, so it stands until the next read
         rdata_ff <= (take && avs_read) ? rd_word(avs_address) : rdata_ff;
      end
   end

   // Channel configuration registers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         for (int i = 0; i < TPO_NCH; i++) begin
            mode_ff[i]  <= MODE_NORMAL;
            ioctl_ff[i] <= IOCTL_RST;
            gra_ff[i]   <= '1;
            grb_ff[i]   <= '0;
            grc_ff[i]   <= '1;
            grd_ff[i]   <= '0;
            cnt_ff[i]   <= '0;
         end
      end else begin
         for (int i = 0; i < TPO_NCH; i++) begin
            cnt_ff[i] <= nxt_cnt[i];
         end
         if (wr_mode && new_ok) begin
            mode_ff[ch_sel] <= tpo_mode_t'(avs_writedata[2:0]);
         end
         if (wr_ch && reg_sel == OFS_IOCTL) begin
            ioctl_ff[ch_sel] <= tpo_ioctl_t'(avs_writedata[3:0]);
         end
         if (wr_ch && reg_sel == OFS_GRA) begin
            gra_ff[ch_sel] <= avs_writedata[CW-1:0];
         end
         if (wr_ch && reg_sel == OFS_GRB) begin
            grb_ff[ch_sel] <= avs_writedata[CW-1:0];
         end
         if (wr_ch && reg_sel == OFS_GRC) begin
            grc_ff[ch_sel] <= avs_writedata[CW-1:0];
         end
         if (wr_ch && reg_sel == OFS_GRD && !wr_fol) begin
            grd_ff[ch_sel] <= avs_writedata[CW-1:0];
         end
      end
   end

   // Duty pipeline: following -> next -> current
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         duty_cur_ff <= '0;
         duty_nxt_ff <= '0;
         duty_fol_ff <= '0;
      end else begin
         if (restart) begin
            duty_cur_ff <= duty_nxt_ff;
         end else if (xfer) begin
            duty_cur_ff <= duty_nxt_ff;
         end
         // A following write reaches next only at a transfer, never with a sync clear
         if (wr_nx) begin
            duty_nxt_ff <= avs_writedata[CW-1:0];
         end else if (xfer && !restart) begin
            duty_nxt_ff <= duty_fol_ff;
         end
         if (wr_fol) begin
            duty_fol_ff <= avs_writedata[CW-1:0];
         end
      end
   end

   // Shared control, status and carrier
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         outctl_ff   <= OUTCTL_RST;
         run_ff      <= '0;
         refused_ff  <= 1'b0;
         down_ff     <= 1'b0;
         chop_cnt_ff <= '0;
         chop_ff     <= 1'b0;
      end else begin
         down_ff     <= nxt_down;
         chop_cnt_ff <= chop_en ? 8'h00 : chop_cnt_ff + 8'h01;
         chop_ff     <= chop_en ? !chop_ff : chop_ff;
         if (wr_do && avs_address == OFS_OUTCTL) begin
            outctl_ff <= tpo_outctl_t'(avs_writedata[2:0]);
         end
         if (wr_do && avs_address == OFS_RUN) begin
            run_ff <= avs_writedata[TPO_NCH-1:0];
         end
         // A refusal in the clearing cycle still sets the flag
         refused_ff <= (wr_mode && !new_ok) || (refused_ff && !clr_ref);
      end
   end

   // Pin flops: levels low and enables high from reset, straight to the port logic
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pins_ff <= '{oe: '1, pin_c: '0, pin_a: '0};
      end else begin
         pins_ff <= nxt_pins;
      end
   end

   assign avs_readdata    = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign timer_out_pins  = pins_ff;

endmodule // tpo_output_ctrl

// ===== tpo_power_stage.sv
// Gate-drive stage on the timer pins: counts edges it is asked to switch
module tpo_power_stage
   import tpo_pkg::*;
(
   input  wire logic               ref_clk,
   input  wire logic               clr,
   input  wire tpo_pins_t          pins,
   output logic [TPO_NCH-1:0][7:0] tog_a,
   output logic [TPO_NCH-1:0][7:0] tog_c
);
   timeunit 1ns;
   timeprecision 100ps;
   tpo_pins_t last_ff; // Gate levels one cycle ago
   // Edge counters; a stage whose drive is cut ignores its gate input
   always_ff @(posedge ref_clk) begin
      last_ff <= pins;
      for (int i = 0; i < TPO_NCH; i++) begin
         if (clr) begin
            tog_a[i] <= 8'h00;
            tog_c[i] <= 8'h00;
         end else if (pins.oe[i]) begin
            tog_a[i] <= tog_a[i] + 8'(pins.pin_a[i] != last_ff.pin_a[i]);
            tog_c[i] <= tog_c[i] + 8'(pins.pin_c[i] != last_ff.pin_c[i]);
         end
      end
   end
endmodule // tpo_power_stage

// ===== tpo_output_ctrl_checker.sv
module tpo_output_ctrl_checker
   import tpo_pkg::*;
(
   input wire logic              ref_clk,
   input wire logic              nrst,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [TPO_DW-1:0] avs_readdata,
   input wire logic              avs_waitrequest,
   input wire logic              standby,
   input wire logic              hw_output_cutoff,
   input wire tpo_pins_t         timer_out_pins
);
   timeunit 1ns;
   timeprecision 100ps;
   // One clock domain, so clocking and reset gating are stated once
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   // A request seen while the slave still waits
   sequence s_taken;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   // The single answer cycle after it
   sequence s_answer;
      s_taken ##1 !avs_waitrequest;
   endsequence
   a_wait_once: assert property (s_taken |=> !avs_waitrequest)
      else $error("access not answered after one wait cycle");
   a_wait_back: assert property (s_answer |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_wait_rest: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest dropped without a request");
   a_rdata_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   a_stby_low: assert property (standby |=> timer_out_pins.pin_a == '0 && timer_out_pins.pin_c == '0)
      else $error("pins not low in standby");
   a_cut_oe: assert property (hw_output_cutoff |=> timer_out_pins.oe[4:3] == 2'h0)
      else $error("large-current pins still enabled under cutoff");
   a_rst_pins: assert property ($rose(nrst) |-> timer_out_pins == {5'h1f, 10'h000})
      else $error("pins not at reset level after reset");
   a_rst_bus: assert property ($rose(nrst) |-> avs_waitrequest && avs_readdata == '0)
      else $error("bus outputs not at rest after reset");
endmodule // tpo_output_ctrl_checker

bind tpo_output_ctrl tpo_output_ctrl_checker tpo_output_ctrl_checker_inst (
   .ref_clk(ref_clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .standby(standby),
   .hw_output_cutoff(hw_output_cutoff), .timer_out_pins(timer_out_pins)
);

// ===== tpo_output_ctrl_tb_top.sv
module tpo_output_ctrl_tb_top
   import tpo_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic                    ref_clk = 1'b0;
   logic                    nrst = 1'b0;
   logic [TPO_AW-1:0]       avs_address = 9'h000;
   logic                    avs_read = 1'b0;
   logic                    avs_write = 1'b0;
   logic [TPO_DW-1:0]       avs_writedata = 32'h0;
   logic [TPO_DW-1:0]       avs_readdata;
   logic                    avs_waitrequest;
   logic                    sync_clear = 1'b0;
   logic                    standby = 1'b0;
   logic                    hw_output_cutoff = 1'b0;
   logic                    clr = 1'b1;      // Holds stage counters at zero
   tpo_pins_t               timer_out_pins;
   logic [TPO_NCH-1:0][7:0] tog_a;
   logic [TPO_NCH-1:0][7:0] tog_c;
   logic [31:0]             q;               // Last read data
   int                      fails = 0;
   int                      tests_run = 0;
   tpo_mode_t               md [6] = '{MODE_NORMAL, MODE_PWM_MODE_ONE, MODE_PWM_MODE_TWO,
                                       MODE_PCM, MODE_COMPLEMENTARY_PWM_MODE, MODE_RESET_SYNC_PWM_MODE};
   logic [8:0]              unm [3] = '{9'h018, 9'h0e8, 9'h1f0}; // Unmapped places
   logic [2:0]              ov [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7}; // Polarity settings

   tpo_output_ctrl tpo_output_ctrl_inst (
      .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sync_clear(sync_clear), .standby(standby),
      .hw_output_cutoff(hw_output_cutoff), .timer_out_pins(timer_out_pins));
   tpo_power_stage tpo_power_stage_inst (
      .ref_clk(ref_clk), .clr(clr), .pins(timer_out_pins), .tog_a(tog_a), .tog_c(tog_c));

   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;

   // Verdict and end of run
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Compare one value with its expectation
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One Avalon access; starts on a fresh edge so the last release has landed
   task automatic av(input logic wr, input logic [8:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      if (n >= 40)
         fails++;
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // Read and compare
   task automatic rd_chk(input logic [8:0] a, input logic [31:0] e);
      av(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   // One-cycle sync clear, sampled after the pins settle
   task automatic pulse_sync();
      @(posedge ref_clk);
      sync_clear <= 1'b1;
      @(posedge ref_clk);
      sync_clear <= 1'b0;
      @(negedge ref_clk);
   endtask
   // Address of a register inside a channel window
   function automatic logic [8:0] ca(int ch, logic [4:0] o);
      return {1'b0, 3'(ch), o};
   endfunction
   // Whether a mode write is accepted on this channel from this mode
   function automatic logic legal(int ch, logic [2:0] p, logic [2:0] m);
      logic cp;
      logic pp;
      cp = (m == MODE_COMPLEMENTARY_PWM_MODE) || (m == MODE_RESET_SYNC_PWM_MODE);
      pp = (p == MODE_PWM_MODE_TWO) || (p == MODE_PCM);
      if ((m == MODE_PCM && ch != 1 && ch != 2) || (cp && ch < 3) || (m == MODE_PWM_MODE_TWO && ch > 2))
         return 1'b0;
      if ((cp && pp) || ((m == MODE_PWM_MODE_TWO || m == MODE_PCM) && (p == MODE_COMPLEMENTARY_PWM_MODE || p == MODE_RESET_SYNC_PWM_MODE)))
         return 1'b0;
      return 1'b1;
   endfunction

   // Watchdog sized well above the expected run
   initial begin
      #(25 * 30000);
      fails++;
      final_report();
   end

   initial begin
      logic [2:0]  cur;
      logic [2:0]  m;
      logic        ok;
      logic [31:0] d;
      d = $urandom(32'h46c4);
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      // Reset contents of every window
      for (int c = 0; c < TPO_NCH; c++) begin
         rd_chk(ca(c, OFS_MODE), 32'h0);
         rd_chk(ca(c, OFS_IOCTL), 32'h0);
         rd_chk(ca(c, OFS_GRA), 32'hffff);
         rd_chk(ca(c, OFS_GRB), 32'h0);
         rd_chk(ca(c, OFS_GRC), 32'hffff);
         rd_chk(ca(c, OFS_GRD), 32'h0);
      end
      rd_chk(OFS_OUTCTL, 32'h3);
      // Unmapped places drop writes and read zero
      foreach (unm[i]) begin
         av(1'b1, unm[i], 32'hffffffff);
         rd_chk(unm[i], 32'h0);
      end
      // Random compare B values, upper bits read zero
      repeat (10) begin
         d = $urandom;
         m = 3'($urandom_range(4));
         av(1'b1, ca(m, OFS_GRB), d);
         rd_chk(ca(m, OFS_GRB), {16'h0, d[15:0]});
      end
      // Every mode once, then random ones; refusals keep the old mode
      for (int c = 0; c < TPO_NCH; c++) begin
         cur = MODE_NORMAL;
         for (int k = 0; k < 14; k++) begin
            m = (k < 6) ? md[k] : md[$urandom_range(5)];
            ok = legal(c, cur, m);
            av(1'b1, ca(c, OFS_MODE), {29'h0, m});
            if (ok)
               cur = m;
            rd_chk(ca(c, OFS_MODE), {29'h0, cur});
            av(1'b0, OFS_STATUS, 32'h0);
            chk({31'h0, q[ST_REFUSED]}, {31'h0, !ok});
            av(1'b1, OFS_STATUS, 32'h1);
         end
         av(1'b1, ca(c, OFS_MODE), 32'h0);
      end
      // PWM_MODE_ONE on ch0 (D buffered only) and ch1 (C buffered)
      for (int c = 0; c < 2; c++) begin
         for (int j = 0; j < 4; j++)
            av(1'b1, ca(c, 5'(8 + 4 * j)), (j == 1) ? 32'h3 : (j == 3) ? 32'h5 : 32'h8);
         av(1'b1, ca(c, OFS_IOCTL), c ? 32'h5 : 32'h9);
         av(1'b1, ca(c, OFS_MODE), 32'h1);
      end
      av(1'b1, OFS_RUN, 32'h3);
      clr <= 1'b0;
      repeat (60) @(posedge ref_clk);
      chk({31'h0, tog_a[0] != 8'h0}, 32'h1);
      chk({31'h0, tog_c[0] != 8'h0}, 32'h1);
      chk({31'h0, tog_a[1] != 8'h0}, 32'h1);
      chk({24'h0, tog_c[1]}, 32'h0);
      // Channel 0 with both C and D buffered: pin C must go quiet
      av(1'b1, ca(0, OFS_IOCTL), 32'hd);
      repeat (2) @(posedge ref_clk);
      d = {24'h0, tog_c[0]};
      repeat (30) @(posedge ref_clk);
      chk({24'h0, tog_c[0]}, d);
      // Standby in mid-run
      standby <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({22'h0, timer_out_pins.pin_c, timer_out_pins.pin_a}, 32'h0);
      @(posedge ref_clk);
      standby <= 1'b0;
      // Random cutoff, then a held one
      repeat (30) begin
         @(posedge ref_clk);
         hw_output_cutoff <= 1'($urandom_range(1));
      end
      @(posedge ref_clk);
      hw_output_cutoff <= 1'b1;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk({30'h0, timer_out_pins.oe[4:3]}, 32'h0);
      @(posedge ref_clk);
      hw_output_cutoff <= 1'b0;
      // Complementary pair on ch3/ch4: sync clear shows inactive levels
      av(1'b1, OFS_RUN, 32'h0);
      for (int c = 3; c < 5; c++) begin
         av(1'b1, ca(c, OFS_IOCTL), 32'h0);
         av(1'b1, ca(c, OFS_MODE), {29'h0, MODE_COMPLEMENTARY_PWM_MODE});
      end
      av(1'b1, OFS_RUN, 32'h18);
      foreach (ov[i]) begin
         av(1'b1, OFS_OUTCTL, {29'h0, ov[i]});
         pulse_sync();
         chk({30'h0, timer_out_pins.pin_a[4:3]}, {30'h0, ~ov[i][1:0]});
         // Negative phase stands idle at duty zero; it moves only with the carrier
         repeat (3) @(posedge ref_clk);
         d = {24'h0, tog_a[4]};
         repeat (40) @(posedge ref_clk);
         chk({31'h0, tog_a[4] != d[7:0]}, {31'h0, ov[i][2]});
      end
      // Following duty write and sync clear leave the next duty alone
      av(1'b1, OFS_RUN, 32'h0);
      d = $urandom;
      av(1'b1, OFS_DUTY_NX, {16'h0, d[15:0]});
      av(1'b1, ca(4, OFS_GRD), {16'h0, d[31:16]});
      rd_chk(OFS_DUTY_NX, {16'h0, d[15:0]});
      pulse_sync();
      rd_chk(OFS_DUTY_NX, {16'h0, d[15:0]});
      final_report();
   end
endmodule // tpo_output_ctrl_tb_top
